/* hdl/bec_map.vh */
// register offsets, field positions and reset values of the block transfer engine
`ifndef BEC_MAP_VH
`define BEC_MAP_VH

// register byte offsets within the register space (host address bit 16 low)
`define BEC_OFF_CONTROL     16'h8000
`define BEC_OFF_STATUS      16'h8004
`define BEC_OFF_COMMAND     16'h8008
`define BEC_OFF_SRC_START   16'h800c
`define BEC_OFF_DST_START   16'h8010
`define BEC_OFF_LINE_PITCH  16'h8014
`define BEC_OFF_WIDTH       16'h8018
`define BEC_OFF_HEIGHT      16'h801c
`define BEC_OFF_BACK_COLOUR 16'h8020
`define BEC_OFF_FORE_COLOUR 16'h8024

// control fields
`define BEC_CTL_ENABLE      0
`define BEC_CTL_SRC_LINEAR  16
`define BEC_CTL_DST_LINEAR  17
`define BEC_CTL_FMT16       18

// status fields
`define BEC_STA_BUSY        0
`define BEC_STA_FULL        4
`define BEC_STA_HALF        5
`define BEC_STA_NOT_EMPTY   6
`define BEC_STA_FREE_LSB    16
`define BEC_STA_USED_LSB    24

// command fields
`define BEC_CMD_OP_LSB      0
`define BEC_CMD_ROP_LSB     16

// operation codes
`define BEC_OP_WRITE        4'h0
`define BEC_OP_READ         4'h1
`define BEC_OP_MOVE_POS     4'h2
`define BEC_OP_MOVE_NEG     4'h3
`define BEC_OP_TWRITE       4'h4
`define BEC_OP_TMOVE        4'h5
`define BEC_OP_PAT          4'h6
`define BEC_OP_TPAT         4'h7
`define BEC_OP_EXP          4'h8
`define BEC_OP_TEXP         4'h9
`define BEC_OP_MEXP         4'ha
`define BEC_OP_TMEXP        4'hb
`define BEC_OP_SOLID        4'hc

// reset values
`define BEC_RST_ZERO32      32'h0000_0000
`define BEC_RST_COLOUR      16'h0000

// data fifo geometry and thresholds
`define BEC_FIFO_DEPTH      5'h10
`define BEC_FIFO_HALF       5'h07
`define BEC_FIFO_FULLMARK   5'h0f
`define BEC_READ_RESUME     5'h0e

`endif

/* hdl/bec_blit_engine.v */
// block transfer engine: host registers, data fifo and pixel sequencer
// Behaviour
// - colour format bit selects 8 bpp when 0, 16 bpp when 1
// - destination linear when bit set, else rectangle stepped by line pitch
// - source linear when bit set, else rectangle stepped by line pitch
// - writing enable 1 starts; host never writes 0 while busy
// - used-entries field reports fifo occupancy
// - free-entries field reports empty entries, zero means full
// - not-empty flag set when fifo holds at least one word
// - full, half, not-empty flags follow the occupancy table
// - half flag set at seven words or more, just under half occupancy
// - full flag set when fifo has at most one free entry
// - busy set while operation runs, cleared on completion
// - read op pauses when fifo fills, resumes below 14 words
// - four-bit raster code combines source or pattern with destination
// - four-bit operation field selects the operation, others reserved
// - 21-bit source start; cpu-sourced data uses only bit 0
// - pattern fill splits source address by colour format
// - destination start from 21-bit register
// - 11-bit line pitch used only in rectangular addressing
// - width in pixels is field plus one
// - height in lines is field plus one
// - background colour gives expansion background and transparency key
// - foreground colour gives expansion and solid fill colour
`timescale 1ns/1ps
`include "bec_map.vh"

module bec_blit_engine (
	// clock and reset
	input  wire        mclk_i,
	input  wire        rst_b_i,
	// host register and data port
	input  wire        host_sel_i,
	input  wire        host_we_i,
	input  wire [16:0] host_addr_i,
	input  wire [31:0] host_wdata_i,
	output wire        host_wait_o,
	output reg  [31:0] host_rdata_o,
	output reg         host_rvalid_o,
	// display memory port
	output wire        mem_req_o,
	output reg         mem_we_o,
	output reg         mem_wide_o,
	output reg  [20:0] mem_addr_o,
	output reg  [15:0] mem_wdata_o,
	input  wire [15:0] mem_rdata_i,
	input  wire        mem_ack_i
);

	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_FETCH = 3'd1;
	localparam [2:0] ST_SRD   = 3'd2;
	localparam [2:0] ST_DRD   = 3'd3;
	localparam [2:0] ST_WR    = 3'd4;
	localparam [2:0] ST_STEP  = 3'd5;
	localparam [2:0] ST_PUSH  = 3'd6;

	// configuration
	reg        fmt16_q;
	reg        dlin_q;
	reg        slin_q;
	reg  [3:0] rop_q;
	reg  [3:0] op_q;
	reg  [20:0] src_q;
	reg  [20:0] dst_q;
	reg  [10:0] pitch_q;
	reg  [9:0] wid_q;
	reg  [9:0] hgt_q;
	reg  [15:0] bg_q;
	reg  [15:0] fg_q;

	// sequencer
	reg  [2:0] st_q;
	reg  [9:0] x_q;
	reg  [9:0] y_q;
	reg  [20:0] sline_q;
	reg  [20:0] dline_q;
	reg  [15:0] spix_q;
	reg  [31:0] cw_q;
	reg  [8:0] wi_q;
	reg        cw_ok_q;
	reg  [31:0] rdw_q;
	reg  [1:0] rdb_q;
	reg        pause_q;
	reg        req_q;

	// fifo
	reg  [31:0] fifo_mem [0:15];
	reg  [3:0] wp_q;
	reg  [3:0] rp_q;
	reg  [4:0] cnt_q;

	wire busy = (st_q != ST_IDLE);
	wire rd_op = (op_q == `BEC_OP_READ);
	wire fifo_full = (cnt_q == `BEC_FIFO_DEPTH);
	wire fifo_empty = (cnt_q == 5'h00);

	// host side decode
	wire dport = host_addr_i[16];
	assign host_wait_o = host_sel_i && dport &&
		(host_we_i ? fifo_full : (fifo_empty && !(busy && !rd_op)));
	wire acc = host_sel_i && !host_wait_o;
	wire reg_wr = acc && host_we_i && !dport;
	wire [15:0] ra = host_addr_i[15:0];
	// data pushed during a read op would corrupt the result stream, so drop it
	wire host_push = acc && host_we_i && dport && !(busy && rd_op);
	// the engine owns the read pointer while it consumes cpu data
	wire host_pop = acc && !host_we_i && dport && !(busy && !rd_op) && !fifo_empty;

	// per-pixel address arithmetic
	wire [1:0] bpb = fmt16_q ? 2'd2 : 2'd1;
	wire [20:0] xoff = fmt16_q ? {10'h000, x_q, 1'b0} : {11'h000, x_q};
	wire neg = (op_q == `BEC_OP_MOVE_NEG);
	wire [20:0] dpix_addr = neg ? dline_q - xoff : dline_q + xoff;
	wire [20:0] spix_addr = neg ? sline_q - xoff : sline_q + xoff;
	wire [20:0] row_bytes = fmt16_q ? {10'h000, wid_q, 1'b0} + 21'd2 : {11'h000, wid_q} + 21'd1;
	wire [20:0] pitch_bytes = {9'h000, pitch_q, 1'b0};
	// pattern is an 8x8 tile; line and pixel offsets wrap inside it
	wire [2:0] pline8 = src_q[5:3] + y_q[2:0];
	wire [2:0] ppix8 = src_q[2:0] + x_q[2:0];
	wire [2:0] pline16 = src_q[6:4] + y_q[2:0];
	wire [2:0] ppix16 = src_q[3:1] + x_q[2:0];
	wire [20:0] pat_addr = fmt16_q ? {src_q[20:7], pline16, ppix16, src_q[0]}
		: {src_q[20:6], pline8, ppix8};

	// expansion bit index: start bit from low raster code bits
	wire [10:0] xn = {1'b0, x_q} + {8'h00, 3'd7 - rop_q[2:0]};
	wire [2:0] ebit = 3'd7 - xn[2:0];
	// cpu stream byte index; only bit 0 of source start is honoured
	wire [10:0] xb = (fmt16_q ? {x_q, 1'b0} : {1'b0, x_q}) + {10'h000, src_q[0]};
	wire is_exp = (op_q == `BEC_OP_EXP) || (op_q == `BEC_OP_TEXP);
	wire is_mexp = (op_q == `BEC_OP_MEXP) || (op_q == `BEC_OP_TMEXP);
	wire is_cpu = (op_q == `BEC_OP_WRITE) || (op_q == `BEC_OP_TWRITE) || is_exp;
	wire is_pat = (op_q == `BEC_OP_PAT) || (op_q == `BEC_OP_TPAT);
	wire is_solid = (op_q == `BEC_OP_SOLID);
	wire [8:0] need_wi = is_exp ? {3'b000, xn[10:5]} : xb[10:2];
	wire [1:0] cbyte = is_exp ? xn[4:3] : xb[1:0];
	wire [31:0] cur_w = (cw_ok_q && wi_q == need_wi) ? cw_q : fifo_mem[rp_q];
	wire [7:0] cb = cur_w[cbyte * 8 +: 8];
	wire [15:0] ch = cbyte[1] ? cur_w[31:16] : cur_w[15:0];
	wire [15:0] cpix = fmt16_q ? ch : {8'h00, cb};
	wire cw_hit = cw_ok_q && (wi_q == need_wi);
	wire cw_avail = cw_hit || !fifo_empty;
	wire eng_pop = (st_q == ST_FETCH) && is_cpu && !cw_hit && !fifo_empty;

	// operation classes
	wire needs_dst = (op_q == `BEC_OP_WRITE) || (op_q == `BEC_OP_MOVE_POS) || neg ||
		(op_q == `BEC_OP_PAT);
	wire transp = (op_q == `BEC_OP_TWRITE) || (op_q == `BEC_OP_TMOVE) ||
		(op_q == `BEC_OP_TPAT);
	wire reserved_op = (op_q > `BEC_OP_SOLID);
	wire [15:0] key = fmt16_q ? bg_q : {8'h00, bg_q[7:0]};
	wire [15:0] fgc = fmt16_q ? fg_q : {8'h00, fg_q[7:0]};
	wire last_x = (x_q == wid_q);
	wire last_px = last_x && (y_q == hgt_q);

	// bitwise raster combine: result bit = rop[{s,d}]
	function [15:0] rop_fn;
		input [3:0] r;
		input [15:0] s;
		input [15:0] d;
		integer k;
		begin
			for (k = 0; k < 16; k = k + 1) begin
				rop_fn[k] = r[{s[k], d[k]}];
			end
		end
	endfunction

	wire [15:0] rop_out = rop_fn(rop_q, spix_q, mem_rdata_i);
	wire [15:0] rop_w = fmt16_q ? rop_out : {8'h00, rop_out[7:0]};
	wire eng_push = (st_q == ST_PUSH) && !pause_q && !fifo_full;

	assign mem_req_o = req_q;

	// status word
	wire [4:0] free_cnt = `BEC_FIFO_DEPTH - cnt_q;
	wire f_full = (cnt_q >= `BEC_FIFO_FULLMARK);
	wire f_half = (cnt_q >= `BEC_FIFO_HALF);
	wire f_ne = !fifo_empty;
	wire [31:0] status_w = {3'b000, cnt_q, 3'b000, free_cnt, 9'h000, f_ne, f_half, f_full,
		3'b000, busy};

	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		case (ra)
			`BEC_OFF_CONTROL:     rd_mux = {13'h0000, fmt16_q, dlin_q, slin_q, 16'h0000};
			`BEC_OFF_STATUS:      rd_mux = status_w;
			`BEC_OFF_COMMAND:     rd_mux = {12'h000, rop_q, 12'h000, op_q};
			`BEC_OFF_SRC_START:   rd_mux = {11'h000, src_q};
			`BEC_OFF_DST_START:   rd_mux = {11'h000, dst_q};
			`BEC_OFF_LINE_PITCH:  rd_mux = {21'h000000, pitch_q};
			`BEC_OFF_WIDTH:       rd_mux = {22'h000000, wid_q};
			`BEC_OFF_HEIGHT:      rd_mux = {22'h000000, hgt_q};
			`BEC_OFF_BACK_COLOUR: rd_mux = {16'h0000, bg_q};
			`BEC_OFF_FORE_COLOUR: rd_mux = {16'h0000, fg_q};
			default:              rd_mux = 32'h0000_0000;
		endcase
	end

	// host read answer, one cycle after acceptance
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			host_rdata_o  <= `BEC_RST_ZERO32;
			host_rvalid_o <= 1'b0;
		end else begin
			host_rvalid_o <= acc && !host_we_i;
			if (acc && !host_we_i) begin
				host_rdata_o <= dport ? fifo_mem[rp_q] : rd_mux;
			end
		end
	end

	// configuration registers; the enable bit itself is never stored
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fmt16_q <= 1'b0;
			dlin_q  <= 1'b0;
			slin_q  <= 1'b0;
			rop_q   <= 4'h0;
			op_q    <= 4'h0;
			src_q   <= 21'h000000;
			dst_q   <= 21'h000000;
			pitch_q <= 11'h000;
			wid_q   <= 10'h000;
			hgt_q   <= 10'h000;
			bg_q    <= `BEC_RST_COLOUR;
			fg_q    <= `BEC_RST_COLOUR;
		end else if (reg_wr) begin
			case (ra)
				`BEC_OFF_CONTROL: begin
					fmt16_q <= host_wdata_i[`BEC_CTL_FMT16];
					dlin_q  <= host_wdata_i[`BEC_CTL_DST_LINEAR];
					slin_q  <= host_wdata_i[`BEC_CTL_SRC_LINEAR];
				end
				`BEC_OFF_COMMAND: begin
					rop_q <= host_wdata_i[`BEC_CMD_ROP_LSB +: 4];
					op_q  <= host_wdata_i[`BEC_CMD_OP_LSB +: 4];
				end
				`BEC_OFF_SRC_START:   src_q   <= host_wdata_i[20:0];
				`BEC_OFF_DST_START:   dst_q   <= host_wdata_i[20:0];
				`BEC_OFF_LINE_PITCH:  pitch_q <= host_wdata_i[10:0];
				`BEC_OFF_WIDTH:       wid_q   <= host_wdata_i[9:0];
				`BEC_OFF_HEIGHT:      hgt_q   <= host_wdata_i[9:0];
				`BEC_OFF_BACK_COLOUR: bg_q    <= host_wdata_i[15:0];
				`BEC_OFF_FORE_COLOUR: fg_q    <= host_wdata_i[15:0];
				default: ;
			endcase
		end
	end

	wire start = reg_wr && (ra == `BEC_OFF_CONTROL) && host_wdata_i[`BEC_CTL_ENABLE] &&
		!busy;

	// data fifo, shared by both directions
	wire do_push = host_push || eng_push;
	wire do_pop = host_pop || eng_pop;
	wire [31:0] push_data = host_push ? host_wdata_i : rdw_q;
	always @(posedge mclk_i) begin
		if (do_push) begin
			fifo_mem[wp_q] <= push_data;
		end
	end

	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wp_q    <= 4'h0;
			rp_q    <= 4'h0;
			cnt_q   <= 5'h00;
			pause_q <= 1'b0;
		end else begin
			if (do_push) begin
				wp_q <= wp_q + 4'h1;
			end
			if (do_pop) begin
				rp_q <= rp_q + 4'h1;
			end
			if (start) begin
				// a new operation starts from an empty queue
				wp_q  <= 4'h0;
				rp_q  <= 4'h0;
				cnt_q <= 5'h00;
			end else if (do_push && !do_pop) begin
				cnt_q <= cnt_q + 5'h01;
			end else if (do_pop && !do_push) begin
				cnt_q <= cnt_q - 5'h01;
			end
			if (fifo_full) begin
				pause_q <= 1'b1;
			end else if (cnt_q < `BEC_READ_RESUME) begin
				pause_q <= 1'b0;
			end
		end
	end

	// pixel sequencer
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q        <= ST_IDLE;
			x_q         <= 10'h000;
			y_q         <= 10'h000;
			sline_q     <= 21'h000000;
			dline_q     <= 21'h000000;
			spix_q      <= 16'h0000;
			cw_q        <= 32'h0000_0000;
			wi_q        <= 9'h000;
			cw_ok_q     <= 1'b0;
			rdw_q       <= 32'h0000_0000;
			rdb_q       <= 2'b00;
			req_q       <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_wide_o  <= 1'b0;
			mem_addr_o  <= 21'h000000;
			mem_wdata_o <= 16'h0000;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (start) begin
						x_q     <= 10'h000;
						y_q     <= 10'h000;
						sline_q <= src_q;
						dline_q <= dst_q;
						cw_ok_q <= 1'b0;
						rdb_q   <= 2'b00;
						rdw_q   <= 32'h0000_0000;
						// format is stored by this same write, so take it from the bus
						mem_wide_o <= host_wdata_i[`BEC_CTL_FMT16];
						st_q    <= reserved_op ? ST_IDLE : ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (is_cpu) begin
						if (cw_avail) begin
							if (!cw_hit) begin
								cw_q    <= fifo_mem[rp_q];
								cw_ok_q <= 1'b1;
								wi_q    <= cw_ok_q ? wi_q + 9'h001 : 9'h000;
							end
							if (is_exp) begin
								spix_q <= cb[ebit] ? fgc : key;
								if (!cb[ebit] && op_q == `BEC_OP_TEXP) begin
									st_q <= ST_STEP;
								end else begin
									st_q <= ST_WR;
								end
							end else begin
								spix_q <= cpix;
								if (op_q == `BEC_OP_TWRITE && cpix == key) begin
									st_q <= ST_STEP;
								end else begin
									st_q <= needs_dst ? ST_DRD : ST_WR;
								end
							end
						end
					end else if (is_solid) begin
						spix_q <= fgc;
						st_q   <= ST_WR;
					end else begin
						req_q    <= 1'b1;
						mem_we_o <= 1'b0;
						if (is_pat) begin
							mem_addr_o <= pat_addr;
						end else if (is_mexp) begin
							mem_addr_o <= sline_q + {13'h0000, xn[10:3]};
						end else begin
							mem_addr_o <= spix_addr;
						end
						mem_wide_o <= is_mexp ? 1'b0 : fmt16_q;
						st_q <= ST_SRD;
					end
				end
				ST_SRD: begin
					if (mem_ack_i) begin
						req_q      <= 1'b0;
						mem_wide_o <= fmt16_q;
						if (rd_op) begin
							if (fmt16_q) begin
								rdw_q[rdb_q[1] * 16 +: 16] <= mem_rdata_i;
							end else begin
								rdw_q[rdb_q * 8 +: 8] <= mem_rdata_i[7:0];
							end
							rdb_q <= rdb_q + bpb;
							if (last_px || (rdb_q + bpb) == 2'b00) begin
								st_q <= ST_PUSH;
							end else begin
								st_q <= ST_STEP;
							end
						end else if (is_mexp) begin
							spix_q <= mem_rdata_i[ebit] ? fgc : key;
							if (!mem_rdata_i[ebit] && op_q == `BEC_OP_TMEXP) begin
								st_q <= ST_STEP;
							end else begin
								st_q <= ST_WR;
							end
						end else begin
							spix_q <= fmt16_q ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
							if (transp && (fmt16_q ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]})
								== key) begin
								st_q <= ST_STEP;
							end else begin
								st_q <= needs_dst ? ST_DRD : ST_WR;
							end
						end
					end
				end
				ST_DRD: begin
					if (!req_q) begin
						req_q      <= 1'b1;
						mem_we_o   <= 1'b0;
						mem_addr_o <= dpix_addr;
					end else if (mem_ack_i) begin
						req_q    <= 1'b0;
						spix_q   <= rop_w;
						st_q     <= ST_WR;
					end
				end
				ST_WR: begin
					if (!req_q) begin
						req_q       <= 1'b1;
						mem_we_o    <= 1'b1;
						mem_addr_o  <= dpix_addr;
						mem_wdata_o <= spix_q;
					end else if (mem_ack_i) begin
						req_q    <= 1'b0;
						mem_we_o <= 1'b0;
						st_q     <= ST_STEP;
					end
				end
				ST_PUSH: begin
					if (eng_push) begin
						rdw_q <= 32'h0000_0000;
						rdb_q <= 2'b00;
						st_q  <= ST_STEP;
					end
				end
				ST_STEP: begin
					if (last_px) begin
						st_q <= ST_IDLE;
					end else if (last_x) begin
						x_q     <= 10'h000;
						y_q     <= y_q + 10'h001;
						cw_ok_q <= 1'b0;
						if (neg) begin
							sline_q <= sline_q - (slin_q ? row_bytes : pitch_bytes);
							dline_q <= dline_q - (dlin_q ? row_bytes : pitch_bytes);
						end else begin
							sline_q <= sline_q + (slin_q ? row_bytes : pitch_bytes);
							dline_q <= dline_q + (dlin_q ? row_bytes : pitch_bytes);
						end
						st_q <= ST_FETCH;
					end else begin
						x_q  <= x_q + 10'h001;
						st_q <= ST_FETCH;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

endmodule

/* verification/bec_assertions.sv */
// port-level checks of the block transfer engine
`timescale 1ns/1ps
module bec_assertions (
	// clock and reset
	input wire        mclk_i,
	input wire        rst_b_i,
	// host side
	input wire        host_sel_i,
	input wire        host_we_i,
	input wire [16:0] host_addr_i,
	input wire [31:0] host_wdata_i,
	input wire        host_wait_o,
	input wire [31:0] host_rdata_o,
	input wire        host_rvalid_o,
	// memory side
	input wire        mem_req_o,
	input wire        mem_we_o,
	input wire        mem_wide_o,
	input wire [20:0] mem_addr_o,
	input wire [15:0] mem_wdata_o,
	input wire [15:0] mem_rdata_i,
	input wire        mem_ack_i
);
	reg  stat_q;
	reg  ctl_q;
	wire take = host_sel_i & ~host_we_i & ~host_wait_o;
	wire st   = stat_q & host_rvalid_o;
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stat_q <= 1'b0;
			ctl_q  <= 1'b0;
		end else begin
			stat_q <= take & (host_addr_i == 17'h08004);
			ctl_q  <= take & (host_addr_i == 17'h08000);
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	mem_hold_a:
		assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
			&& $stable(mem_we_o) && $stable(mem_wdata_o) && $stable(mem_wide_o))
		else $error("memory request changed before ack");
	mem_gap_a:
		assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("memory request not dropped after ack");
	rd_answer_a:
		assert property (take |=> host_rvalid_o)
		else $error("accepted read gave no answer");
	rd_cause_a:
		assert property (host_rvalid_o |-> $past(take))
		else $error("read answer without a read");
	reg_nowait_a:
		assert property (host_sel_i && !host_addr_i[16] |-> !host_wait_o)
		else $error("register access held off");
	used_free_a:
		assert property (st |->
			{1'b0, host_rdata_o[28:24]} + {1'b0, host_rdata_o[20:16]} == 6'h10)
		else $error("used plus free entries not sixteen");
	full_flag_a:
		assert property (st |-> host_rdata_o[4] == (host_rdata_o[28:24] >= 5'h0f))
		else $error("full flag disagrees with used count");
	half_flag_a:
		assert property (st |-> host_rdata_o[5] == (host_rdata_o[28:24] >= 5'h07))
		else $error("half flag disagrees with used count");
	not_empty_a:
		assert property (st |-> host_rdata_o[6] == (host_rdata_o[28:24] != 5'h00))
		else $error("not-empty flag disagrees with used count");
	flag_order_a:
		assert property (st |-> (!host_rdata_o[4] || host_rdata_o[5]) &&
			(!host_rdata_o[5] || host_rdata_o[6]))
		else $error("fifo flags out of order");
	enable_wo_a:
		assert property (ctl_q |-> host_rdata_o[0] == 1'b0)
		else $error("enable bit read back");
	cover property (st && host_rdata_o[4]);
	cover property (mem_req_o && mem_ack_i && mem_we_o);
	cover property (st && host_rdata_o[0]);
endmodule

/* verification/bec_mem_model.sv */
// display memory answering the engine one pixel access at a time
`timescale 1ns/1ps
module bec_mem_model (
	// clock and reset
	input  wire        mclk_i,
	input  wire        rst_b_i,
	// engine side
	input  wire        req_i,
	input  wire        we_i,
	input  wire        wide_i,
	input  wire [20:0] addr_i,
	input  wire [15:0] wdata_i,
	output reg  [15:0] rdata_o,
	output reg         ack_o
);
	reg     [7:0]  mem [0:4095];
	reg     [1:0]  wait_q;
	reg            slow_q;
	wire    [11:0] a = addr_i[11:0];
	integer        i;
	initial begin
		for (i = 0; i < 4096; i = i + 1)
			mem[i] = i[7:0] ^ 8'h5a;
	end
	// alternate prompt and slow answers
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_o   <= 1'b0;
			wait_q  <= 2'h0;
			slow_q  <= 1'b0;
			rdata_o <= 16'h0000;
		end else begin
			ack_o   <= 1'b0;
			// released bus never repeats its last value
			rdata_o <= ~rdata_o;
			if (req_i && !ack_o) begin
				if (wait_q != 2'h0) begin
					wait_q <= wait_q - 2'h1;
				end else begin
					ack_o  <= 1'b1;
					slow_q <= ~slow_q;
					wait_q <= slow_q ? 2'h0 : 2'h2;
					if (we_i) begin
						mem[a] <= wdata_i[7:0];
						if (wide_i)
							mem[a + 12'h1] <= wdata_i[15:8];
					end else begin
						rdata_o <= {wide_i ? mem[a + 12'h1] : 8'h00, mem[a]};
					end
				end
			end
		end
	end
endmodule

/* verification/tb_top.sv */
// self-checking bench for the block transfer engine
`timescale 1ns/1ps
module tb_top;
	reg          mclk = 1'b0;
	reg          rst_b = 1'b0;
	reg          sel = 1'b0;
	reg          we = 1'b0;
	reg   [16:0] addr = 17'h0;
	reg   [31:0] wdata = 32'h0;
	wire         wait_w, rvalid, req, mwe, wide, ack;
	wire  [31:0] rdata;
	wire  [20:0] maddr;
	wire  [15:0] mwdata, mrdata;
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;
	int          k, n;
	logic [31:0] mq[$];
	logic [31:0] eq[$];
	logic [31:0] v, wd, mm, ev;
	logic [15:0] lfsr_q = 16'd3284;
	logic [16:0] off_t[10] = '{17'h08000, 17'h08008, 17'h0800c, 17'h08010, 17'h08014,
		17'h08018, 17'h0801c, 17'h08020, 17'h08024, 17'h08028};
	logic [31:0] msk_t[10] = '{32'h00070000, 32'h000f000f, 32'h001fffff, 32'h001fffff,
		32'h7ff, 32'h3ff, 32'h3ff, 32'hffff, 32'hffff, 32'h0};
	logic [3:0]  rop_t[5] = '{4'h0, 4'hc, 4'hf, 4'h6, 4'h3};

	always #5 mclk = ~mclk;

	bec_blit_engine u_dut (.mclk_i(mclk), .rst_b_i(rst_b), .host_sel_i(sel), .host_we_i(we),
		.host_addr_i(addr), .host_wdata_i(wdata), .host_wait_o(wait_w), .host_rdata_o(rdata),
		.host_rvalid_o(rvalid), .mem_req_o(req), .mem_we_o(mwe), .mem_wide_o(wide),
		.mem_addr_o(maddr), .mem_wdata_o(mwdata), .mem_rdata_i(mrdata), .mem_ack_i(ack));
	bec_mem_model u_mem (.mclk_i(mclk), .rst_b_i(rst_b), .req_i(req), .we_i(mwe), .wide_i(wide),
		.addr_i(maddr), .wdata_i(mwdata), .rdata_o(mrdata), .ack_o(ack));

	function logic [31:0] rnd();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		rnd = {lfsr_q, ~lfsr_q ^ 16'h3c3c};
	endfunction

	// only the raster codes that the scenarios use
	function logic [7:0] rop8(input logic [3:0] r, input logic [7:0] s, input logic [7:0] d);
		case (r)
			4'h0: rop8 = 8'h00;
			4'h3: rop8 = ~s;
			4'h6: rop8 = s ^ d;
			4'hc: rop8 = s;
			default: rop8 = 8'hff;
		endcase
	endfunction

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// held until the wait line lets the access through
	task acc(input logic w, input logic [16:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] e);
		int t;
		t = 0;
		@(posedge mclk);
		sel   <= 1'b1;
		we    <= w;
		addr  <= a;
		wdata <= d;
		if (!w) begin
			mq.push_back(m);
			eq.push_back(e & m);
		end
		@(negedge mclk);
		while (wait_w !== 1'b0 && t < 3000) begin
			@(negedge mclk);
			t++;
		end
		if (t >= 3000) begin
			err_total++;
			results();
		end
		@(posedge mclk);
		sel <= 1'b0;
	endtask

	task rd(input logic [16:0] a, output logic [31:0] r);
		acc(1'b0, a, 32'h0, 32'h0, 32'h0);
		#1 r = rdata;
	endtask

	task idle;
		int          t;
		logic [31:0] s;
		t = 0;
		s = 32'h1;
		while (s[0] !== 1'b0 && t < 500) begin
			rd(17'h08004, s);
			t++;
		end
		if (t >= 500) begin
			err_total++;
			results();
		end
	endtask

	task run(input logic [31:0] ctl, cmd, src, dst, pitch, w, h);
		logic [31:0] p[6];
		p = '{cmd, src, dst, pitch, w, h};
		for (int i = 0; i < 6; i++)
			acc(1'b1, 17'h08008 + 17'(4 * i), p[i], 32'h0, 32'h0);
		acc(1'b1, 17'h08000, ctl, 32'h0, 32'h0);
	endtask

	// oldest noted read result against each answer
	always @(negedge mclk) begin
		if (rvalid === 1'b1) begin
			mm = mq.pop_front();
			ev = eq.pop_front();
			if (mm != 32'h0)
				check("read data", rdata & mm, ev);
		end
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			results();
		end
	end

	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		for (k = 0; k < 11; k++)
			acc(0, 17'h08000 + 17'(4 * k), 0, '1, k == 1 ? 32'h00100000 : 32'h0);
		for (k = 0; k < 10; k++) begin
			wd = rnd() & ~32'h1;
			acc(1'b1, off_t[k], wd, 32'h0, 32'h0);
			acc(0, off_t[k], 0, '1, wd & msk_t[k]);
		end
		acc(1'b1, 17'h08024, 32'h000000a5, 32'h0, 32'h0);
		run(32'h00020001, 32'hc, 32'h0, 32'h100, 32'h0, 32'h2, 32'h1);
		acc(0, 17'h08000, 0, '1, 32'h00020000);
		idle();
		for (k = 0; k < 7; k++)
			check("fill byte", u_mem.mem[12'h100 + k], k < 6 ? 8'ha5 : 8'h5c);
		acc(1'b1, 17'h08024, 32'h0000beef, 32'h0, 32'h0);
		run(32'h00040001, 32'hc, 32'h0, 32'h200, 32'h8, 32'h1, 32'h1);
		idle();
		for (k = 0; k < 20; k++)
			check("fill byte", u_mem.mem[12'h200 + k],
				(k % 16) < 4 ? (k % 2 ? 8'hbe : 8'hef) : 8'(k) ^ 8'h5a);
		for (k = 0; k < 5; k++) begin
			wd = rnd();
			run(32'h00020001, {12'h0, rop_t[k], 16'h0}, 32'h0, 32'h300 + 16 * k, 32'h0, 32'h3,
				32'h0);
			acc(1'b1, 17'h10000, wd, 32'h0, 32'h0);
			idle();
			for (n = 0; n < 4; n++)
				check("rop byte", u_mem.mem[12'h300 + 16 * k + n],
					rop8(rop_t[k], wd[8 * n +: 8], 8'(16 * k + n) ^ 8'h5a));
		end
		// rectangle move, then pattern fill, both into linear destinations
		for (k = 0; k < 2; k++) begin
			run(32'h00020001, k ? 32'h000c0006 : 32'h000c0002, k ? 32'h800 : 32'h500,
				32'h600 + 16 * k, 32'h8, 32'h1, 32'h1);
			idle();
			for (n = 0; n < 4; n++)
				check("copy byte", u_mem.mem[12'h600 + 16 * k + n],
					8'((k ? 8 : 16) * (n / 2) + n % 2) ^ 8'h5a);
		end
		// transparent write skips the key byte, expansion alternates colours
		acc(1'b1, 17'h08020, 32'h00000033, 32'h0, 32'h0);
		for (k = 0; k < 2; k++) begin
			run(32'h00020001, k ? 32'h00070008 : 32'h4, 32'h0, 32'h700 + 16 * k, 32'h0, 32'h3,
				32'h0);
			acc(1'b1, 17'h10000, k ? 32'h000000a0 : 32'h44332211, 32'h0, 32'h0);
			idle();
			for (n = 0; n < 4; n++)
				check("key byte", u_mem.mem[12'h700 + 16 * k + n],
					k ? (n % 2 ? 8'h33 : 8'hef) : (n == 2 ? 8'h58 : 8'(17 * n + 17)));
		end
		// twenty words read back: the fifo fills and the engine holds off
		run(32'h00050001, 32'h1, 32'h400, 32'h0, 32'h0, 32'd39, 32'h0);
		v = 32'h0;
		for (n = 0; n < 300 && v[28:24] !== 5'h10; n++)
			rd(17'h08004, v);
		acc(0, 17'h08004, 0, '1, 32'h10000071);
		for (k = 0; k < 20; k++) begin
			wd = {8'(4 * k + 3), 8'(4 * k + 2), 8'(4 * k + 1), 8'(4 * k)};
			acc(0, 17'h10000, 0, '1, {4{8'h5a}} ^ wd);
			if (k < 2) begin
				repeat (30) @(posedge mclk);
				acc(0, 17'h08004, 0, '1, k ? 32'h0e020061 : 32'h0f010071);
			end
		end
		idle();
		acc(0, 17'h08004, 0, '1, 32'h00100000);
		// a reserved operation code never shows busy
		run(32'h00020001, 32'hd, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
		acc(0, 17'h08004, 0, '1, 32'h00100000);
		results();
	end
endmodule

bind bec_blit_engine bec_assertions u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
	.host_sel_i(host_sel_i), .host_we_i(host_we_i), .host_addr_i(host_addr_i),
	.host_wdata_i(host_wdata_i), .host_wait_o(host_wait_o), .host_rdata_o(host_rdata_o),
	.host_rvalid_o(host_rvalid_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
	.mem_wide_o(mem_wide_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
	.mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));
